// File: design/dracc_pkg.sv
// Summary of operation
// R1 - A data write stores the whole byte at the current page and column.
// R2 - In normal mode the column advances by one after each data write.
// R3 - Host signals a data write with select high, read strobe high, write low.
// R4 - A data read first returns the byte already held in the output latch.
// R5 - After the latch is read it reloads from memory at page and column.
// R6 - In normal mode the column advances by one after the latch reload.
// R7 - Host discards the first read after setting a new address.
// R8 - Writes go straight into memory, so no throwaway write is needed.
// R9 - Host signals a data read with select high, read strobe low, write high.
// R10 - Command byte E0 enters read-modify-write mode.
// R11 - In that mode reads leave the column alone; writes still advance it.
// R12 - Host must not change the column while read-modify-write is active.
// R13 - Entering the mode saves the column; the end command restores it.
// R14 - Command byte EE ends read-modify-write mode.
// R15 - Command byte E2 is a software reset.
// R16 - Software reset clears start line to zero, page to three; all else kept.
// R17 - Host still applies hardware reset at power-up.
// R18 - Column is a 7-bit counter that stops at 50H.
// R19 - Page is a 2-bit register selecting a group of eight lines.
// R20 - End command outside the mode does nothing.
// R21 - Undefined command codes are ignored.
package dracc_pkg;
    localparam int DATA_W = 8;
    localparam int COL_W = 7;
    localparam int PAGE_W = 2;
    localparam int START_W = 5;
    localparam int RAM_AW = PAGE_W + COL_W;
    localparam int RAM_DEPTH = 1 << RAM_AW;
    localparam int OP_W = 2;
    localparam int WORD_W = OP_W + DATA_W;
    localparam int FIFO_DEPTH = 32;

    localparam logic [DATA_W-1:0] CMD_RMW_ENTER = 8'he0;
    localparam logic [DATA_W-1:0] CMD_RMW_END = 8'hee;
    localparam logic [DATA_W-1:0] CMD_SOFT_RESET = 8'he2;

    localparam logic [COL_W-1:0] COL_MAX = 7'h50;
    localparam logic [COL_W-1:0] COL_STEP = 7'h01;
    localparam logic [COL_W-1:0] COL_RESET = 7'h00;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 2'h0;
    localparam logic [PAGE_W-1:0] PAGE_SOFT = 2'h3;
    localparam logic [START_W-1:0] START_RESET = 5'h00;
    localparam logic [START_W-1:0] START_SOFT = 5'h00;
    localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;

    // Queued operation kinds, upper bits of each queue word
    localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
    localparam logic [OP_W-1:0] OP_READ = 2'h2;
    localparam logic [OP_W-1:0] OP_CMD = 2'h3;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b01,
        MODE_RMW = 2'b10
    } dracc_mode_e;
endpackage

// File: design/dracc_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dracc_fifo_if #(parameter int WIDTH = 8);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport store (
        input push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data
    );
    modport user (
        output push_valid, push_data, pop_ready,
        input push_ready, pop_valid, pop_data
    );
endinterface
`default_nettype wire

// File: design/dracc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module dracc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    dracc_fifo_if.store q
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;

    // Full and empty come straight from the occupancy count
    assign q.push_ready = (count != FULL_COUNT);
    assign q.pop_valid = (count != '0);
    assign q.pop_data = mem[rd_ptr];
    assign do_push = q.push_valid && q.push_ready;
    assign do_pop = q.pop_valid && q.pop_ready;

    // Storage has no reset; only the pointers define contents
    always_ff @(posedge clk_i)
    begin
        if (do_push)
            mem[wr_ptr] <= q.push_data;
    end

    // Pointers wrap explicitly so depth need not be a power of two
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
            if (do_pop)
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
            if (do_push && !do_pop)
                count <= count + 1'b1;
            else if (do_pop && !do_push)
                count <= count - 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: design/dracc_ram.sv
`timescale 1ns/100ps
`default_nettype none
module dracc_ram (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [dracc_pkg::RAM_AW-1:0] addr_i,
    input wire logic [dracc_pkg::DATA_W-1:0] wdata_i,
    output logic [dracc_pkg::DATA_W-1:0] rdata_o
);
    logic [dracc_pkg::DATA_W-1:0] cells [dracc_pkg::RAM_DEPTH];

    // Read is combinational so the latch reload fits in one queue step
    assign rdata_o = cells[addr_i];

    // Whole-byte write, no byte masking
    always_ff @(posedge clk_i)
    begin
        if (we_i)
            cells[addr_i] <= wdata_i;
    end
endmodule
`default_nettype wire

// File: design/dracc_top.sv
`timescale 1ns/100ps
`default_nettype none
module dracc_top (
    input wire logic CLK_I,
    input wire logic RESET_I,
    // Host parallel bus, sampled as synchronous to CLK_I
    input wire logic CD_I,
    input wire logic RD_N_I,
    input wire logic WR_N_I,
    input wire logic [dracc_pkg::DATA_W-1:0] HOST_DATA_LINES_I,
    output logic [dracc_pkg::DATA_W-1:0] HOST_DATA_LINES_O,
    output logic HOST_DATA_LINES_OE_N_O,
    // Address presets from the set-column and set-page logic
    input wire logic COL_LOAD_I,
    input wire logic [dracc_pkg::COL_W-1:0] COL_VALUE_I,
    input wire logic PAGE_LOAD_I,
    input wire logic [dracc_pkg::PAGE_W-1:0] PAGE_VALUE_I,
    input wire logic START_LOAD_I,
    input wire logic [dracc_pkg::START_W-1:0] START_VALUE_I,
    // Memory owner stall, e.g. display refresh
    input wire logic HOLD_I,
    // State seen by the rest of the driver
    output logic [dracc_pkg::COL_W-1:0] COLUMN_O,
    output logic [dracc_pkg::PAGE_W-1:0] PAGE_O,
    output logic [dracc_pkg::START_W-1:0] START_LINE_O,
    output logic RMW_MODE_O,
    output logic BUSY_O,
    output logic OVERRUN_O
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////////
    logic rd_n_q;
    logic wr_n_q;
    logic write_start;
    logic read_end;
    logic push_req;
    logic [dracc_pkg::WORD_W-1:0] push_word;

    logic [dracc_pkg::COL_W-1:0] column;
    logic [dracc_pkg::COL_W-1:0] saved_column;
    logic [dracc_pkg::COL_W-1:0] next_column;
    logic [dracc_pkg::PAGE_W-1:0] page;
    logic [dracc_pkg::START_W-1:0] start_line;
    logic [dracc_pkg::DATA_W-1:0] out_latch;
    dracc_pkg::dracc_mode_e mode;
    dracc_pkg::dracc_mode_e next_mode;
    logic overrun;
    logic oe_n;

    logic exec;
    logic [dracc_pkg::OP_W-1:0] op;
    logic [dracc_pkg::DATA_W-1:0] op_data;
    logic op_write;
    logic op_read;
    logic op_cmd;
    logic cmd_enter;
    logic cmd_end;
    logic cmd_soft;
    logic col_bump;
    logic [dracc_pkg::DATA_W-1:0] ram_rdata;
    logic [dracc_pkg::RAM_AW-1:0] ram_addr;

    dracc_fifo_if #(.WIDTH(dracc_pkg::WORD_W)) queue ();

    ////////////////////////////////////////////////////////////////////////////
    // Host strobe decode
    ////////////////////////////////////////////////////////////////////////////

    // Previous strobe levels for edge detection; idle high
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end
        else
        begin
            rd_n_q <= RD_N_I;
            wr_n_q <= WR_N_I;
        end
    end

    // Writes and commands are taken as the write strobe falls
    assign write_start = wr_n_q && !WR_N_I && RD_N_I; // R3
    // Read reload is queued when the read strobe rises, after the host saw the latch
    assign read_end = !rd_n_q && RD_N_I && CD_I && WR_N_I; // R9

    // Queue word: operation kind above the byte
    always_comb
    begin
        push_req = 1'b0;
        push_word = '0;
        if (write_start)
        begin
            push_req = 1'b1;
            push_word = {CD_I ? dracc_pkg::OP_WRITE : dracc_pkg::OP_CMD, HOST_DATA_LINES_I};
        end
        else if (read_end)
        begin
            push_req = 1'b1;
            push_word = {dracc_pkg::OP_READ, {dracc_pkg::DATA_W{1'b0}}};
        end
    end

    assign queue.push_valid = push_req;
    assign queue.push_data = push_word;

    // A strobe that meets a full queue is lost; flag it sticky until reset
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            overrun <= 1'b0;
        else if (push_req && !queue.push_ready)
            overrun <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation queue
    ////////////////////////////////////////////////////////////////////////////

    // Host cycles are far slower than CLK_I; the queue absorbs refresh stalls
    dracc_fifo #(
        .WIDTH(dracc_pkg::WORD_W),
        .DEPTH(dracc_pkg::FIFO_DEPTH)
    ) u_queue (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .q(queue.store)
    );

    assign queue.pop_ready = !HOLD_I;
    assign exec = queue.pop_valid && queue.pop_ready;
    assign op = queue.pop_data[dracc_pkg::WORD_W-1:dracc_pkg::DATA_W];
    assign op_data = queue.pop_data[dracc_pkg::DATA_W-1:0];
    assign op_write = exec && (op == dracc_pkg::OP_WRITE);
    assign op_read = exec && (op == dracc_pkg::OP_READ);
    assign op_cmd = exec && (op == dracc_pkg::OP_CMD); // R21

    // Only three codes decode here; anything else falls through untouched
    assign cmd_enter = op_cmd && (op_data == dracc_pkg::CMD_RMW_ENTER); // R10
    assign cmd_end = op_cmd && (op_data == dracc_pkg::CMD_RMW_END); // R14
    assign cmd_soft = op_cmd && (op_data == dracc_pkg::CMD_SOFT_RESET); // R15

    ////////////////////////////////////////////////////////////////////////////
    // Display memory
    ////////////////////////////////////////////////////////////////////////////

    assign ram_addr = {page, column}; // R19

    // Write data lands in the cells directly; no dummy cycle needed
    dracc_ram u_ram (
        .clk_i(CLK_I),
        .we_i(op_write), // R1 R8
        .addr_i(ram_addr),
        .wdata_i(op_data),
        .rdata_o(ram_rdata)
    );

    // Output latch reloads only after a read has been served from it
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            out_latch <= dracc_pkg::LATCH_RESET;
        else if (op_read)
            out_latch <= ram_rdata; // R5
    end

    // Host always sees the latch, never the current cell
    assign HOST_DATA_LINES_O = out_latch; // R4

    // Drive the bus one cycle behind a data read strobe being low, registered on CLK_I
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            oe_n <= 1'b1;
        else
            oe_n <= !(CD_I && !RD_N_I && WR_N_I); // R4
    end

    assign HOST_DATA_LINES_OE_N_O = oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Mode and column counter
    ////////////////////////////////////////////////////////////////////////////

    // Enter and end are ignored when already in the target mode
    always_comb
    begin
        next_mode = mode;
        case (mode)
            dracc_pkg::MODE_NORMAL:
            begin
                if (cmd_enter)
                    next_mode = dracc_pkg::MODE_RMW; // R10
            end
            dracc_pkg::MODE_RMW:
            begin
                if (cmd_end)
                    next_mode = dracc_pkg::MODE_NORMAL; // R14
            end
            default:
                next_mode = dracc_pkg::MODE_NORMAL;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            mode <= dracc_pkg::MODE_NORMAL;
        else
            mode <= next_mode;
    end

    // Saved copy taken only on a real entry into the mode
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            saved_column <= dracc_pkg::COL_RESET;
        else if (cmd_enter && mode == dracc_pkg::MODE_NORMAL)
            saved_column <= column; // R13
    end

    // Writes always advance; reads advance only outside the mode
    assign col_bump = op_write || (op_read && mode == dracc_pkg::MODE_NORMAL); // R2 R6 R11

    // Counter saturates at the last valid column
    always_comb
    begin
        next_column = column;
        if (cmd_end && mode == dracc_pkg::MODE_RMW)
            next_column = saved_column; // R13
        else if (col_bump && column < dracc_pkg::COL_MAX)
            next_column = column + dracc_pkg::COL_STEP; // R18
        if (COL_LOAD_I)
            next_column = COL_VALUE_I;
    end

    // An end outside the mode leaves the counter as it was
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            column <= dracc_pkg::COL_RESET;
        else
            column <= next_column; // R20
    end

    ////////////////////////////////////////////////////////////////////////////
    // Page and start line
    ////////////////////////////////////////////////////////////////////////////

    // Software reset touches only these two; a preset in the same cycle wins
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            page <= dracc_pkg::PAGE_RESET;
        else if (PAGE_LOAD_I)
            page <= PAGE_VALUE_I;
        else if (cmd_soft)
            page <= dracc_pkg::PAGE_SOFT; // R16
    end

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            start_line <= dracc_pkg::START_RESET;
        else if (START_LOAD_I)
            start_line <= START_VALUE_I;
        else if (cmd_soft)
            start_line <= dracc_pkg::START_SOFT; // R16
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status outputs
    ////////////////////////////////////////////////////////////////////////////

    assign COLUMN_O = column;
    assign PAGE_O = page;
    assign START_LINE_O = start_line;
    assign RMW_MODE_O = (mode == dracc_pkg::MODE_RMW);
    // Busy while work is queued; a read issued now would see a stale latch
    assign BUSY_O = queue.pop_valid || !queue.push_ready;
    assign OVERRUN_O = overrun;
endmodule
`default_nettype wire

// File: bench/dracc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module dracc_checker (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic CD_I,
    input wire logic RD_N_I,
    input wire logic WR_N_I,
    input wire logic COL_LOAD_I,
    input wire logic PAGE_LOAD_I,
    input wire logic START_LOAD_I,
    input wire logic [dracc_pkg::DATA_W-1:0] HOST_DATA_LINES_O,
    input wire logic HOST_DATA_LINES_OE_N_O,
    input wire logic [dracc_pkg::COL_W-1:0] COLUMN_O,
    input wire logic [dracc_pkg::PAGE_W-1:0] PAGE_O,
    input wire logic [dracc_pkg::START_W-1:0] START_LINE_O,
    input wire logic RMW_MODE_O,
    input wire logic BUSY_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);
    ////////////////////////////////////////////////////////////////////////////
    // Host bus phases
    sequence s_write_edge;
        $fell(WR_N_I) && RD_N_I;
    endsequence
    sequence s_read_held;
        CD_I && !RD_N_I && WR_N_I;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    // Bus drive and output latch
    a_oe_drive: assert property (s_read_held |=> !HOST_DATA_LINES_OE_N_O)
        else $error("bus not driven during read");
    a_oe_release: assert property (RD_N_I |=> HOST_DATA_LINES_OE_N_O)
        else $error("bus still driven after read");
    // Latch only moves when a queued read runs, so idle queue means steady bus
    a_latch_steady: assert property ((!RD_N_I && !BUSY_O) |=> $stable(HOST_DATA_LINES_O))
        else $error("latch changed during read strobe");
    a_write_taken: assert property (s_write_edge |=> BUSY_O)
        else $error("write strobe not queued");
    ////////////////////////////////////////////////////////////////////////////
    // Address registers
    a_col_step: assert property (($changed(COLUMN_O) && !$past(COL_LOAD_I) && !$past(RMW_MODE_O))
        |-> COLUMN_O == $past(COLUMN_O) + 7'h01) else $error("column moved by other than one");
    a_col_stop: assert property ((COLUMN_O == 7'h50 && !RMW_MODE_O && !COL_LOAD_I) |=> COLUMN_O == 7'h50)
        else $error("column passed its limit");
    a_rmw_enter: assert property ($rose(RMW_MODE_O) |-> $stable(COLUMN_O) || $past(COL_LOAD_I))
        else $error("column moved on mode entry");
    a_soft_page: assert property (($changed(PAGE_O) && !$past(PAGE_LOAD_I)) |-> PAGE_O == 2'h3)
        else $error("page changed to other than three");
    a_soft_start: assert property (($changed(START_LINE_O) && !$past(START_LOAD_I)) |-> START_LINE_O == 5'h00)
        else $error("start line changed to nonzero");
endmodule
bind dracc_top dracc_checker dracc_checker_inst (.*);
`default_nettype wire

// File: bench/dracc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dracc_host_model (
    input wire logic clk_i,
    input wire logic oe_n_i,
    input wire logic [dracc_pkg::DATA_W-1:0] dev_data_i,
    output logic cd_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [dracc_pkg::DATA_W-1:0] data_o
);
    logic drive = 1'b0;
    logic [dracc_pkg::DATA_W-1:0] val = 8'h00;
    initial {cd_o, rd_n_o, wr_n_o} = 3'b111;
    ////////////////////////////////////////////////////////////////////////////
    // Shared wire; released bus shows inverse so a stale byte cannot pass
    assign data_o = !oe_n_i ? dev_data_i : (drive ? val : ~val);
    // Data or command cycle; select picks which
    task automatic wr(input logic cd, input logic [7:0] b);
        @(negedge clk_i);
        {cd_o, val, drive} = {cd, b, 1'b1};
        wr_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        wr_n_o = 1'b1;
        repeat (2) @(negedge clk_i);
        drive = 1'b0;
    endtask
    // Sample late in the strobe, where the device bus has settled
    task automatic rd(output logic [7:0] b);
        @(negedge clk_i);
        {cd_o, rd_n_o} = 2'b10;
        repeat (3) @(negedge clk_i);
        b = data_o;
        rd_n_o = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// File: bench/tb_display_ram_access_commands.sv
`timescale 1ns/100ps
`default_nettype none
module tb_display_ram_access_commands;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cd, rd_n, wr_n, oe_n, col_load, page_load, start_load, hold, rmw, busy, overrun;
    logic [7:0] din, dout;
    logic [6:0] col, col_val;
    logic [1:0] page, page_val;
    logic [4:0] start, start_val;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    initial
    begin
        forever #5 clk = ~clk;
    end
    dracc_top dracc_top_inst (.CLK_I(clk), .RESET_I(rst), .CD_I(cd), .RD_N_I(rd_n), .WR_N_I(wr_n),
        .HOST_DATA_LINES_I(din), .HOST_DATA_LINES_O(dout), .HOST_DATA_LINES_OE_N_O(oe_n),
        .COL_LOAD_I(col_load), .COL_VALUE_I(col_val), .PAGE_LOAD_I(page_load), .PAGE_VALUE_I(page_val),
        .START_LOAD_I(start_load), .START_VALUE_I(start_val), .HOLD_I(hold), .COLUMN_O(col),
        .PAGE_O(page), .START_LINE_O(start), .RMW_MODE_O(rmw), .BUSY_O(busy), .OVERRUN_O(overrun));
    dracc_host_model host_inst (.clk_i(clk), .oe_n_i(oe_n), .dev_data_i(dout), .cd_o(cd),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(din));
    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask
    // Bounded wait for the queue to drain
    task automatic settle();
        repeat (40) if (busy === 1'b1) @(negedge clk);
    endtask
    task automatic op(input logic c, input logic [7:0] b);
        host_inst.wr(c, b);
        settle();
    endtask
    task automatic rd(output logic [7:0] b);
        host_inst.rd(b);
        settle();
    endtask
    task automatic load(input logic [6:0] c, input logic [1:0] p, input logic [4:0] s);
        @(negedge clk);
        {col_val, page_val, start_val} = {c, p, s};
        {col_load, page_load, start_load} = 3'b111;
        @(negedge clk);
        {col_load, page_load, start_load} = 3'b000;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_rw();
        logic [7:0] d;
        load(7'h10, 2'h1, 5'h00);
        op(1'b1, 8'ha5);
        op(1'b1, 8'h5a);
        chk("column after writes", 18'h12, {11'h0, col});
        load(7'h10, 2'h2, 5'h00);
        op(1'b1, 8'h3c);
        load(7'h10, 2'h1, 5'h00);
        rd(d);
        rd(d);
        chk("first read", 18'ha5, {10'h0, d});
        rd(d);
        chk("second read", 18'h5a, {10'h0, d});
        chk("column after reads", 18'h13, {11'h0, col});
    endtask
    task automatic t_limit();
        load(7'h4f, 2'h0, 5'h00);
        repeat (3) op(1'b1, 8'h77);
        chk("column at limit", 18'h50, {11'h0, col});
    endtask
    task automatic t_rmw();
        logic [7:0] d;
        load(7'h10, 2'h1, 5'h00);
        op(1'b0, 8'he0);
        chk("mode entered", 18'h1, {17'h0, rmw});
        rd(d);
        rd(d);
        chk("mode read", 18'ha5, {10'h0, d});
        chk("mode read column", 18'h10, {11'h0, col});
        op(1'b1, 8'hc3);
        chk("mode write column", 18'h11, {11'h0, col});
        // A repeated entry must not overwrite the saved column
        op(1'b0, 8'he0);
        chk("second entry column", 18'h11, {11'h0, col});
        op(1'b0, 8'hee);
        chk("mode end", 18'h010, {10'h0, rmw, col});
        rd(d);
        rd(d);
        chk("modified byte", 18'hc3, {10'h0, d});
    endtask
    task automatic t_cmds();
        load(7'h2a, 2'h1, 5'h1a);
        op(1'b0, 8'hee);
        op(1'b0, 8'h55);
        chk("ignored commands", {4'h0, 2'h1, 5'h1a, 7'h2a}, {3'h0, rmw, page, start, col});
        op(1'b0, 8'he2);
        chk("soft reset", {4'h0, 2'h3, 5'h00, 7'h2a}, {3'h0, rmw, page, start, col});
    endtask
    // Stalled drain fills the queue until the next strobe is lost
    task automatic t_fifo();
        load(7'h00, 2'h0, 5'h00);
        hold = 1'b1;
        repeat (33) host_inst.wr(1'b1, 8'h99);
        chk("queue full", 18'h3, {16'h0, busy, overrun});
        hold = 1'b0;
        settle();
        chk("queue drained", {9'h0, 7'h20, 2'b01}, {9'h0, col, busy, overrun});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and hang guard
    initial
    begin
        {col_load, col_val, page_load, page_val, start_load, start_val, hold} = '0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        chk("reset state", 18'h1, {col, page, start, rmw, busy, overrun, oe_n});
        t_rw();
        t_limit();
        t_rmw();
        t_cmds();
        t_fifo();
        summarize();
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            errors++;
            summarize();
        end
    end
endmodule
`default_nettype wire
